/* fnc_pkg.sv */
// Package: constants and carrier types for the fieldbus node config block
`default_nettype none
package fnc_pkg;
   // Address and bit-rate ranges
   localparam logic [3:0] DIGIT_MAX     = 4'h9;
   localparam logic [6:0] ADDR_MAX      = 7'h3f;
   localparam logic [3:0] RATE_SEL_MAX  = 4'h2;
   localparam logic [1:0] SYNC_FILL     = 2'h3;
   localparam logic [1:0] RATE_125      = 2'h0;
   localparam logic [1:0] RATE_250      = 2'h1;
   localparam logic [1:0] RATE_500      = 2'h2;
   // Network object identifiers
   localparam logic [7:0] CLS_LINK      = 8'h03;
   localparam logic [7:0] ATTR_ADDR     = 8'h01;
   localparam logic [7:0] ATTR_RATE     = 8'h02;
   localparam logic [7:0] CLS_STORE     = 8'h25;
   localparam logic [7:0] ATTR_SAVE     = 8'h65;
   // Blink timing: half period in ms at 20 MHz
   localparam int         CLK_HZ        = 20_000_000;
   localparam int         BLINK_HALF_MS = 500;
   localparam int         BLINK_CYC     = CLK_HZ / 1000 * BLINK_HALF_MS;
   localparam logic [23:0] BLINK_LAST   = 24'(BLINK_CYC - 1);
   localparam logic [23:0] CNT_ZERO     = 24'h000000;

   // Indicator states, Gray coded along dark->blink green->green
   typedef enum logic [2:0] {
      FNC_DARK   = 3'b000,
      FNC_BLINKG = 3'b001,
      FNC_GREEN  = 3'b011,
      FNC_BLINKR = 3'b010,
      FNC_RED    = 3'b110
   } fnc_led_t;

   // Node condition flags from the protocol engine
   typedef struct packed {
      logic online;
      logic dup_check_done;
      logic connected;
      logic allocated;
      logic config_ok;
      logic recoverable_err;
      logic io_waiting;
      logic fatal;
   } fnc_cond_t;

   // Network attribute write
   typedef struct packed {
      logic       valid;
      logic [7:0] cls;
      logic [7:0] attr;
      logic [7:0] data;
   } fnc_objwr_t;

   // Stored configuration
   typedef struct packed {
      logic [5:0] addr;
      logic [1:0] rate;
   } fnc_cfg_t;
endpackage
`default_nettype wire

/* fnc_sync3.sv */
// Three-stage synchroniser for a bundle of switch inputs
`default_nettype none
module fnc_sync3 #(
   parameter int W = 12
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q,
   output logic              stable
);
   logic [W-1:0] s1_r, s2_r, s3_r;

   // First stage is read only by the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign q      = s3_r;
   assign stable = (s2_r == s3_r);
endmodule // fnc_sync3
`default_nettype wire

/* fnc_node_cfg.sv */
// Fieldbus node configuration selection and status indicator
// How it works
// - Indicator stays dark while not online or before duplicate check done, unless fatal.
// - Steady green when online, connected, allocated to a master and configured.
// - Blinking green when online but unconnected, unallocated or unconfigured.
// - Blinking red on recoverable error or a waiting I/O connection.
// - Steady red on fatal fault such as duplicate address or bus-off.
// - Switches 0..63 give the address, tens and units digits.
// - Switches above 63 select the stored address, set by terminal.
// - Network write class 0x03 attribute 1 sets stored address, only while switches are above 63.
// - Rate switch 0,1,2 selects 125, 250, 500 kbit/s directly.
// - Rate switch above 2 selects the stored rate set by terminal.
// - Network write class 0x03 attribute 2 stores encoded rate 0..2, only while rate switch is above 2.
// - Network changes need save via class 0x25 attr 0x65, then restart.
`default_nettype none
module fnc_node_cfg (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [3:0]       address_tens_switch,
   input  wire logic [3:0]       address_units_switch,
   input  wire logic [3:0]       rate_switch,
   input  wire logic             cold_restart_cmd,
   input  wire logic             set_node_address_cmd,
   input  wire logic             set_bit_rate_cmd,
   input  wire logic [7:0]       cmd_value,
   input  wire logic             save_cmd,
   input  wire fnc_pkg::fnc_objwr_t obj_wr,
   input  wire fnc_pkg::fnc_cfg_t   nv_cfg,
   input  wire fnc_pkg::fnc_cond_t  cond,
   output logic [5:0]            node_addr,
   output logic [1:0]            bit_rate,
   output logic                  cfg_valid,
   output logic                  nv_save,
   output fnc_pkg::fnc_cfg_t     nv_data,
   output logic                  led_green,
   output logic                  led_red
);
   ////////////////////////////////////////////////////////////////////////
   // Switch synchronisation
   logic [11:0] sw_q;
   logic        sw_stable;

   fnc_sync3 #(.W(12)) u_sync (
      .clk    (clk),
      .nrst   (nrst),
      .d      ({address_tens_switch, address_units_switch, rate_switch}),
      .q      (sw_q),
      .stable (sw_stable)
   );

   ////////////////////////////////////////////////////////////////////////
   // Configuration selection
   // Active config only refreshes while not yet latched; a restart reopens it
   logic              latched_r, latched_nxt;
   logic [5:0]        addr_r, addr_nxt;
   logic [1:0]        rate_r, rate_nxt;
   fnc_pkg::fnc_cfg_t stored_r, stored_nxt;
   logic              save_r, save_nxt;
   logic [6:0]        sw_addr;
   logic              addr_sw_ok, rate_sw_ok, dig_ok;
   logic [1:0]        warm_r, warm_nxt;
   logic              sample_go;

   // Tens digit times ten plus units, digits above nine force stored value
   always_comb begin
      sw_addr    = 7'(sw_q[11:8]) * 7'h0a + 7'(sw_q[7:4]);
      dig_ok     = (sw_q[11:8] <= fnc_pkg::DIGIT_MAX) &&
                   (sw_q[7:4] <= fnc_pkg::DIGIT_MAX);
      addr_sw_ok = dig_ok && (sw_addr <= fnc_pkg::ADDR_MAX);
      rate_sw_ok = (sw_q[3:0] <= fnc_pkg::RATE_SEL_MAX);
      // A freshly reset chain reads stable on zeros, so wait until it fills
      sample_go  = !latched_r && sw_stable &&
                   (warm_r == fnc_pkg::SYNC_FILL);
   end

   always_comb begin
      latched_nxt = latched_r;
      warm_nxt    = (warm_r == fnc_pkg::SYNC_FILL) ? warm_r
                                                   : warm_r + 2'h1;
      addr_nxt    = addr_r;
      rate_nxt    = rate_r;
      stored_nxt  = stored_r;
      save_nxt    = 1'b0;
      if (cold_restart_cmd) begin
         latched_nxt = 1'b0;
      end else if (sample_go) begin
         latched_nxt = 1'b1;
         addr_nxt = addr_sw_ok ? sw_addr[5:0] : nv_cfg.addr;
         rate_nxt = rate_sw_ok ? sw_q[1:0] : nv_cfg.rate;
         stored_nxt = nv_cfg;
      end else if (latched_r) begin
         // Terminal commands, takes 125/250 as decimal and 500 as its low byte 0xf4
         if (set_node_address_cmd && cmd_value <= 8'(fnc_pkg::ADDR_MAX))
            stored_nxt.addr = cmd_value[5:0];
         if (set_bit_rate_cmd) begin
            case (cmd_value)
               8'h7d:   stored_nxt.rate = fnc_pkg::RATE_125;
               8'hfa:   stored_nxt.rate = fnc_pkg::RATE_250;
               8'hf4:   stored_nxt.rate = fnc_pkg::RATE_500;
               default: stored_nxt.rate = stored_r.rate;
            endcase
         end
         // Network object writes, accepted only when switch is out of range
         if (obj_wr.valid && obj_wr.cls == fnc_pkg::CLS_LINK) begin
            if (obj_wr.attr == fnc_pkg::ATTR_ADDR && !addr_sw_ok &&
                obj_wr.data <= 8'(fnc_pkg::ADDR_MAX))
               stored_nxt.addr = obj_wr.data[5:0];
            if (obj_wr.attr == fnc_pkg::ATTR_RATE && !rate_sw_ok &&
                obj_wr.data <= 8'(fnc_pkg::RATE_SEL_MAX))
               stored_nxt.rate = obj_wr.data[1:0];
         end
         // Save only writes memory; values apply after restart
         if (save_cmd || (obj_wr.valid && obj_wr.cls == fnc_pkg::CLS_STORE &&
                          obj_wr.attr == fnc_pkg::ATTR_SAVE))
            save_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latched_r <= 1'b0;
         warm_r    <= '0;
         addr_r    <= '0;
         rate_r    <= fnc_pkg::RATE_125;
         stored_r  <= '0;
         save_r    <= 1'b0;
      end else begin
         latched_r <= latched_nxt;
         warm_r    <= warm_nxt;
         addr_r    <= addr_nxt;
         rate_r    <= rate_nxt;
         stored_r  <= stored_nxt;
         save_r    <= save_nxt;
      end
   end

   assign node_addr = addr_r;
   assign bit_rate  = rate_r;
   assign cfg_valid = latched_r;
   assign nv_save   = save_r;
   assign nv_data   = stored_r;

   ////////////////////////////////////////////////////////////////////////
   // Status indicator
   fnc_pkg::fnc_led_t st_r, st_nxt;
   logic [23:0]       cnt_r, cnt_nxt;
   logic              ph_r, ph_nxt;
   logic              grn_r, grn_nxt, red_r, red_nxt;

   // Priority: fatal, then dark, then recoverable, then normal states
   always_comb begin
      if (cond.fatal)
         st_nxt = fnc_pkg::FNC_RED;
      else if (!cond.online || !cond.dup_check_done || !latched_r)
         st_nxt = fnc_pkg::FNC_DARK;
      else if (cond.recoverable_err || cond.io_waiting)
         st_nxt = fnc_pkg::FNC_BLINKR;
      else if (cond.connected && cond.allocated && cond.config_ok)
         st_nxt = fnc_pkg::FNC_GREEN;
      else
         st_nxt = fnc_pkg::FNC_BLINKG;
      cnt_nxt = (cnt_r == fnc_pkg::BLINK_LAST) ? fnc_pkg::CNT_ZERO
                                               : cnt_r + 24'h000001;
      ph_nxt  = (cnt_r == fnc_pkg::BLINK_LAST) ? !ph_r : ph_r;
      case (st_r)
         fnc_pkg::FNC_GREEN:  begin grn_nxt = 1'b1; red_nxt = 1'b0; end
         fnc_pkg::FNC_BLINKG: begin grn_nxt = ph_r; red_nxt = 1'b0; end
         fnc_pkg::FNC_BLINKR: begin grn_nxt = 1'b0; red_nxt = ph_r; end
         fnc_pkg::FNC_RED:    begin grn_nxt = 1'b0; red_nxt = 1'b1; end
         default:             begin grn_nxt = 1'b0; red_nxt = 1'b0; end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r  <= fnc_pkg::FNC_DARK;
         cnt_r <= fnc_pkg::CNT_ZERO;
         ph_r  <= 1'b0;
         grn_r <= 1'b0;
         red_r <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         ph_r  <= ph_nxt;
         grn_r <= grn_nxt;
         red_r <= red_nxt;
      end
   end

   assign led_green = grn_r;
   assign led_red   = red_r;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   a_dark_offline: assert property (@(posedge clk) disable iff (!nrst)
      (!cond.fatal && !cond.online) ##2 1 |-> !led_green && !led_red)
      else $error("indicator lit while offline");
   a_green_steady: assert property (@(posedge clk) disable iff (!nrst)
      st_r == fnc_pkg::FNC_GREEN |=> led_green && !led_red)
      else $error("green not steady");
   a_blink_green: assert property (@(posedge clk) disable iff (!nrst)
      st_r == fnc_pkg::FNC_BLINKG |=> led_green == $past(ph_r) && !led_red)
      else $error("green blink wrong");
   a_blink_red: assert property (@(posedge clk) disable iff (!nrst)
      (cond.io_waiting && cond.online && cond.dup_check_done && latched_r
       && !cond.fatal) |=> st_r == fnc_pkg::FNC_BLINKR)
      else $error("red blink not entered");
   a_red_fatal: assert property (@(posedge clk) disable iff (!nrst)
      cond.fatal ##1 cond.fatal |=> led_red && !led_green)
      else $error("fatal not steady red");
   a_addr_switch: assert property (@(posedge clk) disable iff (!nrst)
      (sample_go && !cold_restart_cmd && addr_sw_ok)
      |=> node_addr == $past(sw_addr[5:0]))
      else $error("switch address not taken");
   a_addr_stored: assert property (@(posedge clk) disable iff (!nrst)
      (sample_go && !cold_restart_cmd && !addr_sw_ok)
      |=> node_addr == $past(nv_cfg.addr))
      else $error("stored address not taken");
   a_rate_hold: assert property (@(posedge clk) disable iff (!nrst)
      (latched_r && !cold_restart_cmd) |=> bit_rate == $past(bit_rate)
      && node_addr == $past(node_addr))
      else $error("config changed without restart");
   a_save_pulse: assert property (@(posedge clk) disable iff (!nrst)
      (latched_r && !cold_restart_cmd && obj_wr.valid &&
       obj_wr.cls == fnc_pkg::CLS_STORE && obj_wr.attr == fnc_pkg::ATTR_SAVE)
      |=> nv_save)
      else $error("save not issued");
   a_net_rate: assert property (@(posedge clk) disable iff (!nrst)
      (latched_r && !cold_restart_cmd && !set_bit_rate_cmd && obj_wr.valid &&
       obj_wr.cls == fnc_pkg::CLS_LINK && obj_wr.attr == fnc_pkg::ATTR_RATE &&
       !rate_sw_ok && obj_wr.data <= 8'h02)
      |=> nv_data.rate == $past(obj_wr.data[1:0]))
      else $error("network rate not stored");
endmodule // fnc_node_cfg
`default_nettype wire

/* fnc_nv_model.sv */
// Non-volatile memory model that stands behind the save request
`default_nettype none
module fnc_nv_model (
   input  wire logic              clk,
   input  wire logic              nv_save,
   input  wire fnc_pkg::fnc_cfg_t nv_data,
   output fnc_pkg::fnc_cfg_t      nv_cfg
);
   timeunit 1ns;
   timeprecision 1ps;
   fnc_pkg::fnc_cfg_t mem_r;
   fnc_pkg::fnc_cfg_t mem_nxt;
   // Contents survive reset, as real memory would
   initial mem_r = 8'h00;
   // Only a save request commits the block's stored copy
   always_comb begin
      mem_nxt = nv_save ? nv_data : mem_r;
   end
   always @(posedge clk) begin
      mem_r <= mem_nxt;
   end
   assign nv_cfg = mem_r;
endmodule // fnc_nv_model
`default_nettype wire

/* tb_fnc_node_cfg.sv */
// Self-checking testbench for the node configuration block
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb_fnc_node_cfg;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, nrst = 1'b0, cold_restart_cmd = 1'b0, save_cmd = 1'b0;
   logic set_node_address_cmd = 1'b0, set_bit_rate_cmd = 1'b0;
   logic [3:0] address_tens_switch = 4'h0, address_units_switch = 4'h0;
   logic [3:0] rate_switch = 4'h0;
   logic [7:0] cmd_value = 8'h00;
   fnc_pkg::fnc_objwr_t obj_wr = '0;
   fnc_pkg::fnc_cond_t cond = '0;
   fnc_pkg::fnc_cfg_t nv_cfg, nv_data;
   logic [5:0] node_addr;
   logic [1:0] bit_rate;
   logic cfg_valid, nv_save, led_green, led_red, cv_prev = 1'b0;
   int err_count = 0, n_compared = 0, a;
   logic [1:0] r;
   logic [7:0] cfg_q[$], nv_q[$];
   logic [19:0] now_q[$]; // Mask and expected value
   event look;
   // Far side: cond table {cond, expected green/red, mask green/red}
   logic [11:0] led_tab[7] = '{12'h003, 12'h803, 12'hf8b, 12'hc01,
                               12'hc22, 12'hfc2, 12'h017};
   always #25 clk = ~clk;
   fnc_node_cfg uut (.clk(clk), .nrst(nrst),
      .address_tens_switch(address_tens_switch),
      .address_units_switch(address_units_switch), .rate_switch(rate_switch),
      .cold_restart_cmd(cold_restart_cmd),
      .set_node_address_cmd(set_node_address_cmd),
      .set_bit_rate_cmd(set_bit_rate_cmd), .cmd_value(cmd_value),
      .save_cmd(save_cmd), .obj_wr(obj_wr), .nv_cfg(nv_cfg), .cond(cond),
      .node_addr(node_addr), .bit_rate(bit_rate), .cfg_valid(cfg_valid),
      .nv_save(nv_save), .nv_data(nv_data), .led_green(led_green),
      .led_red(led_red));
   fnc_nv_model nvm (.clk(clk), .nv_save(nv_save), .nv_data(nv_data),
      .nv_cfg(nv_cfg));
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
   endtask
   task automatic restart(logic [7:0] exp);
      cfg_q.push_back(exp);
      cold_restart_cmd <= 1'b1;
      tick();
      cold_restart_cmd <= 1'b0;
      tick(15);
   endtask
   task automatic obj(logic [7:0] c, logic [7:0] t, logic [7:0] d);
      obj_wr <= '{1'b1, c, t, d};
      tick();
      obj_wr <= '0;
   endtask
   task test_done();
      if (err_count == 0 && n_compared > 0 && cfg_q.size() == 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Monitor: results are judged on the falling edge, away from updates
   always @(negedge clk) begin
      logic [19:0] n;
      if (cfg_valid && !cv_prev && cfg_q.size() > 0) begin
         `CHK({node_addr, bit_rate}, cfg_q.pop_front())
      end
      if (nv_save && nv_q.size() > 0) begin
         `CHK(nv_data, nv_q.pop_front())
      end
      cv_prev = cfg_valid;
   end
   // Wait for the falling edge so the launching edge has settled
   always @(look) begin
      logic [19:0] n;
      @(negedge clk);
      n = now_q.pop_front();
      `CHK({node_addr, bit_rate, led_green, led_red} & n[19:10], n[9:0])
   end
   // Watchdog: the whole sequence needs about 122 cycles, the limit is 5000
   initial begin
      #(5000 * 50);
      err_count++;
      test_done();
   end
   initial begin
      void'($urandom(32'ha1ab69c2));
      a = $urandom % 64;
      address_tens_switch <= 4'(a / 10);
      address_units_switch <= 4'(a % 10);
      r = 2'($urandom % 3);
      rate_switch <= 4'(r);
      tick();
      cfg_q.push_back({6'(a), r});
      tick(3);
      nrst <= 1'b1;
      tick(20);
      // Indicator states, blinking colours masked for the lit lamp
      foreach (led_tab[i]) begin
         cond <= led_tab[i][11:4];
         tick(4);
         now_q.push_back({8'h00, led_tab[i][1:0], 8'h00, led_tab[i][3:2]});
         ->look;
      end
      cond <= '0;
      // Switch moves after sampling are ignored until restart
      address_tens_switch <= 4'h9;
      address_units_switch <= 4'h9;
      rate_switch <= 4'h7;
      tick(10);
      now_q.push_back({10'h3fc, 6'(a), r, 2'h0});
      ->look;
      restart(8'h00);
      // Terminal commands, then save and restart
      set_node_address_cmd <= 1'b1;
      cmd_value <= 8'd17;
      tick();
      set_node_address_cmd <= 1'b0;
      set_bit_rate_cmd <= 1'b1;
      cmd_value <= 8'hf4;
      tick();
      set_bit_rate_cmd <= 1'b0;
      nv_q.push_back({6'd17, 2'h2});
      save_cmd <= 1'b1;
      tick();
      save_cmd <= 1'b0;
      tick(3);
      restart({6'd17, 2'h2});
      // Network object writes, back to back
      obj(8'h03, 8'h01, 8'd33);
      obj(8'h03, 8'h02, 8'h01);
      nv_q.push_back({6'd33, 2'h1});
      obj(8'h25, 8'h65, 8'h00);
      tick(3);
      restart({6'd33, 2'h1});
      test_done();
   end
endmodule // tb_fnc_node_cfg
`default_nettype wire
